//--- verilog/cpu_bus_unit.sv
// processor end: bus cycle control with backoff, ready and cycle definition
`timescale 1ns/1ps
`include "bus_cycle_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: sampled backoff aborts any cycle in progress
// R2: backoff floats address, strobes, data, definition outputs
// R3: outputs stay floated until backoff sampled negated
// R4: others may drive bus while floated
// R5: system asserts ready with valid read data
// R6: system asserts ready once write data latched
// R7: ready completes special cycles
// R8: either ready copy completes transfers
// R9: duplicate ready at reset release picks drive
// R10: bus request while cycle pending internally
// R11: arbiter may use bus request
// R12: reads: cacheable output shows cacheability
// R13: writes: cacheable only for modified writeback
// R14: everything timed on the one bus clock
// R15: data/code separates data from code fetches
// R16: data/code also encodes acknowledge and special
// R17: byte enable n qualifies data byte n
// R18: aborted cycle restarts with new address phase
// R19: backoff and ready sampled on rising edge
module cpu_bus_unit
	import bus_cycle_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// request from the core
	input wire logic req_valid,
	output logic req_ready,
	input wire cycle_kind_type req_kind,
	input wire logic [31:3] req_addr,
	input wire logic [7:0] req_byte_en_n,
	input wire logic [63:0] req_wdata,
	input wire logic req_cacheable,
	input wire logic req_lock,
	input wire logic req_pcd,
	input wire logic req_pwt,
	input wire logic req_split,
	// answer to the core
	output logic done,
	output logic [63:0] rdata,
	output logic aborted,
	output logic drive_strong,
	// bus side
	bus_cycle_if.cpu bus
);
	////////////////////////////////////////////////////////////////////////////
	// state
	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD} state_type;
	state_type state_r, state_nxt;           // bus phase
	logic pend_r, pend_nxt;                  // a cycle is latched and not done
	cycle_kind_type kind_r, kind_nxt;        // latched kind
	logic [31:3] addr_r, addr_nxt;           // latched address
	logic [7:0] be_r, be_nxt;                // latched byte enables
	logic [63:0] wdata_r, wdata_nxt;         // latched write data
	logic [3:0] attr_r, attr_nxt;            // cacheable, lock, pcd, pwt
	logic split_r, split_nxt;                // split cycle attribute
	logic done_r, done_nxt;                  // completion pulse
	logic abort_r, abort_nxt;                // abort pulse
	logic [63:0] rdata_r, rdata_nxt;         // captured read data
	logic drv_r, drv_nxt;                    // drive strength select
	logic rst_d_r;                           // reset delayed, to find release
	logic ready;                             // merged ready copies
	logic is_write;                          // latched cycle writes
	logic [2:0] cyc_def;                     // {mem_io, data_code, write_read}
	logic cache_act;                         // cacheable output, active high

	// both copies complete a transfer alike; inputs are same-clock logic
	assign ready = !bus.burst_ready_n || !bus.burst_ready_dup_n; // see R8 see R7
	assign is_write = (kind_r == KIND_MEM_WRITE) || (kind_r == KIND_WRITEBACK)
		|| (kind_r == KIND_IO_WRITE);

	////////////////////////////////////////////////////////////////////////////
	// cycle definition encoding
	always_comb begin
		case (kind_r)
			KIND_MEM_READ: cyc_def = `CYC_MEM_READ; // see R15
			KIND_CODE_READ: cyc_def = `CYC_CODE_READ; // see R15
			KIND_MEM_WRITE: cyc_def = `CYC_MEM_WRITE;
			KIND_WRITEBACK: cyc_def = `CYC_MEM_WRITE;
			KIND_IO_READ: cyc_def = `CYC_IO_READ;
			KIND_IO_WRITE: cyc_def = `CYC_IO_WRITE;
			KIND_INT_ACK: cyc_def = `CYC_INT_ACK; // see R16
			KIND_SPECIAL: cyc_def = `CYC_SPECIAL; // see R16
			default: cyc_def = `CYC_SPECIAL;
		endcase
		// writes flag only modified-line writebacks, reads flag cacheability
		if (is_write) begin
			cache_act = (kind_r == KIND_WRITEBACK); // see R13
		end else begin
			cache_act = attr_r[3] && (kind_r == KIND_MEM_READ
				|| kind_r == KIND_CODE_READ); // see R12
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus phase next state
	always_comb begin
		state_nxt = state_r;
		pend_nxt = pend_r;
		kind_nxt = kind_r;
		addr_nxt = addr_r;
		be_nxt = be_r;
		wdata_nxt = wdata_r;
		attr_nxt = attr_r;
		split_nxt = split_r;
		done_nxt = 1'b0;
		abort_nxt = 1'b0;
		rdata_nxt = rdata_r;
		// latch a new core request only when nothing is pending
		if (req_valid && !pend_r) begin
			pend_nxt = 1'b1;
			kind_nxt = req_kind;
			addr_nxt = req_addr;
			be_nxt = req_byte_en_n;
			wdata_nxt = req_wdata;
			attr_nxt = {req_cacheable, req_lock, req_pcd, req_pwt};
			split_nxt = req_split;
		end
		// backoff is checked first: it aborts a cycle in the address or data phase
		if (!bus.backoff_n) begin // see R19
			if (state_r == ST_ADDR || state_r == ST_DATA) begin
				abort_nxt = 1'b1; // see R1
			end
			state_nxt = ST_HOLD; // see R2
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (pend_r) begin
						state_nxt = ST_ADDR;
					end
				end
				ST_ADDR: begin
					state_nxt = ST_DATA;
				end
				ST_DATA: begin
					// ready ends read, write and special cycles alike
					if (ready) begin // see R7 see R19
						state_nxt = ST_IDLE;
						pend_nxt = 1'b0;
						done_nxt = 1'b1;
						if (!is_write) begin
							rdata_nxt = bus.sys_data; // see R5
						end
					end
				end
				ST_HOLD: begin
					// aborted cycle stays pending and reissues its address
					state_nxt = pend_r ? ST_ADDR : ST_IDLE; // see R3 see R18
				end
				default: state_nxt = ST_IDLE;
			endcase
		end
	end

	// drive strength: duplicate ready caught at reset release
	always_comb begin
		drv_nxt = drv_r;
		if (rst_d_r) begin
			drv_nxt = !bus.burst_ready_dup_n; // see R9
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk) begin // see R14
		rst_d_r <= rst;
		if (rst) begin
			state_r <= ST_IDLE;
			pend_r <= 1'b0;
			kind_r <= KIND_MEM_READ;
			addr_r <= '0;
			be_r <= 8'hff;
			wdata_r <= '0;
			attr_r <= 4'h0;
			split_r <= 1'b0;
			done_r <= 1'b0;
			abort_r <= 1'b0;
			rdata_r <= '0;
			drv_r <= `DRIVE_SEL_RST;
		end else begin
			state_r <= state_nxt;
			pend_r <= pend_nxt;
			kind_r <= kind_nxt;
			addr_r <= addr_nxt;
			be_r <= be_nxt;
			wdata_r <= wdata_nxt;
			attr_r <= attr_nxt;
			split_r <= split_nxt;
			done_r <= done_nxt;
			abort_r <= abort_nxt;
			rdata_r <= rdata_nxt;
			drv_r <= drv_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; control floats while in hold
	assign req_ready = !pend_r;
	assign done = done_r;
	assign rdata = rdata_r;
	assign aborted = abort_r;
	assign drive_strong = drv_r;
	assign bus.ctl_oe = (state_r != ST_HOLD); // see R2 see R3
	assign bus.addr = addr_r;
	assign bus.addr_strobe_n = (state_r != ST_ADDR);
	assign bus.addr_strobe_dup_n = (state_r != ST_ADDR);
	assign bus.addr_parity = ^addr_r;
	assign bus.byte_enable_n = be_r; // see R17
	assign bus.cache_n = !(cache_act && state_r != ST_IDLE);
	assign bus.mem_io = cyc_def[2];
	assign bus.data_code = cyc_def[1]; // see R15 see R16
	assign bus.write_read = cyc_def[0];
	assign bus.lock_n = !attr_r[2];
	assign bus.page_cache_disable = attr_r[1];
	assign bus.page_write_through = attr_r[0];
	assign bus.split_cycle = split_r;
	assign bus.bus_request = pend_r; // see R10
	assign bus.hit_modified_n = 1'b1;
	assign bus.cpu_data = wdata_r;
	assign bus.cpu_data_oe = is_write && (state_r == ST_DATA); // see R2
	// even parity per byte lane
	genvar g;
	generate
		for (g = 0; g < `LANES; g = g + 1) begin : g_par
			assign bus.cpu_data_parity[g] = ^wdata_r[g*8 +: 8];
		end
	endgenerate
endmodule : cpu_bus_unit

//--- verilog/bus_cycle_defs.svh
// bus cycle control constants: field widths, encodings, drive strength reset value
`ifndef BUS_CYCLE_DEFS_SVH
`define BUS_CYCLE_DEFS_SVH
`define ADDR_HI 31
`define ADDR_LO 3
`define DRV_ADDR_HI 20
`define DATA_W 64
`define LANES 8
// cycle definition encoding {mem_io, data_code, write_read}
`define CYC_INT_ACK 3'b000
`define CYC_SPECIAL 3'b001
`define CYC_IO_READ 3'b010
`define CYC_IO_WRITE 3'b011
`define CYC_CODE_READ 3'b100
`define CYC_MEM_READ 3'b110
`define CYC_MEM_WRITE 3'b111
// reset value of drive strength select
`define DRIVE_SEL_RST 1'b1
`endif

//--- verilog/bus_cycle_pkg.sv
// bus cycle control types shared by both ends
package bus_cycle_pkg;
	// kind of bus cycle requested by the core
	typedef enum logic [2:0] {
		KIND_MEM_READ,
		KIND_CODE_READ,
		KIND_MEM_WRITE,
		KIND_WRITEBACK,
		KIND_IO_READ,
		KIND_IO_WRITE,
		KIND_INT_ACK,
		KIND_SPECIAL
	} cycle_kind_type;
endpackage : bus_cycle_pkg

//--- verilog/bus_cycle_if.sv
// interface joining the processor bus unit and the system logic
`timescale 1ns/1ps
interface bus_cycle_if;
	// processor driven, with per-group output enables
	logic [31:3] addr;
	logic addr_strobe_n;
	logic addr_strobe_dup_n;
	logic addr_parity;
	logic [7:0] byte_enable_n;
	logic cache_n;
	logic data_code;
	logic lock_n;
	logic mem_io;
	logic page_cache_disable;
	logic page_write_through;
	logic split_cycle;
	logic write_read;
	logic bus_request;
	logic hit_modified_n;
	logic ctl_oe;
	// data bus, two-way: each end drives with its own enable
	logic [63:0] cpu_data;
	logic [7:0] cpu_data_parity;
	logic cpu_data_oe;
	logic [63:0] sys_data;
	logic [7:0] sys_data_parity;
	logic sys_data_oe;
	// system driven
	logic backoff_n;
	logic burst_ready_n;
	logic burst_ready_dup_n;
	modport cpu (
		output addr, addr_strobe_n, addr_strobe_dup_n, addr_parity, byte_enable_n,
		output cache_n, data_code, lock_n, mem_io, page_cache_disable,
		output page_write_through, split_cycle, write_read, bus_request,
		output hit_modified_n, ctl_oe, cpu_data, cpu_data_parity, cpu_data_oe,
		input sys_data, sys_data_parity, sys_data_oe,
		input backoff_n, burst_ready_n, burst_ready_dup_n
	);
	modport sys (
		input addr, addr_strobe_n, addr_strobe_dup_n, addr_parity, byte_enable_n,
		input cache_n, data_code, lock_n, mem_io, page_cache_disable,
		input page_write_through, split_cycle, write_read, bus_request,
		input hit_modified_n, ctl_oe, cpu_data, cpu_data_parity, cpu_data_oe,
		output sys_data, sys_data_parity, sys_data_oe,
		output backoff_n, burst_ready_n, burst_ready_dup_n
	);
endinterface : bus_cycle_if

//--- verilog/sys_bus_logic.sv
// system end: answers bus cycles with ready and can force backoff
`timescale 1ns/1ps
`include "bus_cycle_defs.svh"
module sys_bus_logic
	import bus_cycle_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// user side
	input wire logic backoff_req,
	input wire logic use_dup_ready,
	input wire logic [63:0] read_data,
	output logic [63:0] write_data,
	output logic write_valid,
	output logic bus_request_seen,
	// bus side
	bus_cycle_if.sys bus
);
	typedef enum logic [1:0] {SS_IDLE, SS_WAIT, SS_RDY} sstate_type;
	sstate_type st_r, st_nxt;        // cycle tracking
	logic [63:0] wd_r, wd_nxt;       // captured write data
	logic wv_r, wv_nxt;              // capture pulse
	logic [63:0] rd_r, rd_nxt;       // read data driven
	logic wr_r, wr_nxt;              // cycle is a write

	////////////////////////////////////////////////////////////////////////////
	// next state: ready two clocks after the strobe, in the data phase
	always_comb begin
		st_nxt = st_r;
		wd_nxt = wd_r;
		wv_nxt = 1'b0;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		if (backoff_req) begin
			st_nxt = SS_IDLE; // aborted cycle will be reissued
		end else begin
			case (st_r)
				SS_IDLE: begin
					if (bus.ctl_oe && !bus.addr_strobe_n) begin
						st_nxt = SS_WAIT;
						wr_nxt = bus.write_read;
						rd_nxt = read_data; // see R5
					end
				end
				SS_WAIT: st_nxt = SS_RDY;
				SS_RDY: begin
					st_nxt = SS_IDLE;
					if (wr_r) begin
						wd_nxt = bus.cpu_data; // see R6
						wv_nxt = 1'b1;
					end
				end
				default: st_nxt = SS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk) begin // see R14
		if (rst) begin
			st_r <= SS_IDLE;
			wd_r <= '0;
			wv_r <= 1'b0;
			rd_r <= '0;
			wr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			wd_r <= wd_nxt;
			wv_r <= wv_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
		end
	end

	// ready on one copy only, chosen by user; either completes the cycle
	assign bus.burst_ready_n = !(st_r == SS_RDY && !use_dup_ready); // see R7
	assign bus.burst_ready_dup_n = !(st_r == SS_RDY && use_dup_ready); // see R8
	assign bus.backoff_n = !backoff_req;
	assign bus.sys_data = rd_r;
	// drive read data only in the ready clock
	assign bus.sys_data_oe = (st_r == SS_RDY) && !wr_r; // see R5 see R4
	genvar g;
	generate
		for (g = 0; g < `LANES; g = g + 1) begin : g_par
			assign bus.sys_data_parity[g] = ^rd_r[g*8 +: 8];
		end
	endgenerate
	assign write_data = wd_r;
	assign write_valid = wv_r;
	assign bus_request_seen = bus.bus_request; // see R11
endmodule : sys_bus_logic

//--- sim/bus_cycle_checker.sv
// checker: timing relations between the two ends on the joining interface
`timescale 1ns/1ps
module bus_cycle_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// system driven
	input wire logic backoff_n,
	input wire logic burst_ready_n,
	input wire logic burst_ready_dup_n,
	// processor driven
	input wire logic addr_strobe_n,
	input wire logic ctl_oe,
	input wire logic cpu_data_oe,
	input wire logic bus_request,
	input wire logic cache_n,
	input wire logic mem_io,
	input wire logic data_code,
	input wire logic write_read
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// either ready copy counts; a floated strobe is no address phase
	wire logic rdy = !burst_ready_n || !burst_ready_dup_n;
	wire logic ads = !addr_strobe_n && ctl_oe;
	////////////////////////////////////////////////////////////////
	a_backoff_floats: assert property (!backoff_n |=> !ctl_oe && !cpu_data_oe)
		else $error("bus not floated after backoff");
	a_float_until_release: assert property ($rose(ctl_oe) |-> $past(backoff_n))
		else $error("bus driven again while backoff held");
	a_restart_cycle: assert property ($rose(backoff_n) && bus_request |-> ##[1:2] ads)
		else $error("aborted cycle not reissued");
	a_strobe_pending: assert property (ads |-> bus_request)
		else $error("address phase without bus request");
	a_ready_ends: assert property (rdy && backoff_n && ctl_oe |=> addr_strobe_n)
		else $error("cycle not ended by ready");
	a_write_cache: assert property (ads && write_read && !cache_n |-> mem_io && data_code)
		else $error("cacheable write not a memory writeback");
	a_code_read: assert property (ads && mem_io && !data_code |-> !write_read)
		else $error("code access marked as write");
	a_io_uncached: assert property (ads && !mem_io |-> cache_n)
		else $error("non memory cycle marked cacheable");
	// main scenarios reached
	c_backoff: cover property (!backoff_n ##1 !ctl_oe);
	c_dup_ready: cover property (!burst_ready_dup_n && ctl_oe);
	c_writeback: cover property (ads && write_read && !cache_n);
endmodule : bus_cycle_checker

//--- sim/tb_top.sv
// testbench: both bus ends joined, driven from the core and system user sides
`timescale 1ns/1ps
`include "bus_cycle_defs.svh"
module tb_top;
	import bus_cycle_pkg::*;
	// core side
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	cycle_kind_type req_kind = KIND_MEM_READ;
	logic [31:3] req_addr = 29'h0000_0000;
	logic [7:0] req_byte_en_n = 8'hff;
	logic [63:0] req_wdata = 64'h0000_0000_0000_0000;
	logic req_cacheable = 1'b1;
	logic req_ready, done, aborted, drive_strong;
	logic [63:0] rdata, write_data, wr_seen, cur_wd;
	// system side
	logic backoff_req = 1'b0;
	logic use_dup_ready = 1'b0;
	logic [63:0] read_data = 64'h0000_0000_0000_0000;
	logic write_valid, bus_request_seen;
	int fails = 0;
	int n_compared = 0;
	int n_abort = 0;
	// expected {mem_io, data_code, write_read} per kind, in enum order
	logic [2:0] encs [8] = '{`CYC_MEM_READ, `CYC_CODE_READ, `CYC_MEM_WRITE, `CYC_MEM_WRITE,
		`CYC_IO_READ, `CYC_IO_WRITE, `CYC_INT_ACK, `CYC_SPECIAL};
	bus_cycle_if i_bus_cycle_if();
	wire logic [2:0] cyc_def = {i_bus_cycle_if.mem_io, i_bus_cycle_if.data_code,
		i_bus_cycle_if.write_read};
	cpu_bus_unit i_cpu_bus_unit(.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
		.req_byte_en_n(req_byte_en_n), .req_wdata(req_wdata), .req_cacheable(req_cacheable),
		.req_lock(1'b0), .req_pcd(1'b0), .req_pwt(1'b0), .req_split(1'b0), .done(done),
		.rdata(rdata), .aborted(aborted), .drive_strong(drive_strong), .bus(i_bus_cycle_if));
	sys_bus_logic i_sys_bus_logic(.ref_clk(ref_clk), .rst(rst), .backoff_req(backoff_req),
		.use_dup_ready(use_dup_ready), .read_data(read_data), .write_data(write_data),
		.write_valid(write_valid), .bus_request_seen(bus_request_seen), .bus(i_bus_cycle_if));
	bus_cycle_checker i_bus_cycle_checker(.ref_clk(ref_clk), .rst(rst),
		.backoff_n(i_bus_cycle_if.backoff_n), .burst_ready_n(i_bus_cycle_if.burst_ready_n),
		.burst_ready_dup_n(i_bus_cycle_if.burst_ready_dup_n),
		.addr_strobe_n(i_bus_cycle_if.addr_strobe_n), .ctl_oe(i_bus_cycle_if.ctl_oe),
		.cpu_data_oe(i_bus_cycle_if.cpu_data_oe), .bus_request(i_bus_cycle_if.bus_request),
		.cache_n(i_bus_cycle_if.cache_n), .mem_io(i_bus_cycle_if.mem_io),
		.data_code(i_bus_cycle_if.data_code), .write_read(i_bus_cycle_if.write_read));
	////////////////////////////////////////////////////////////////
	// 125 MHz bus clock
	always #4 ref_clk = ~ref_clk;
	// write_valid and aborted are one-cycle pulses, so catch them on every rising edge
	always @(posedge ref_clk) begin
		if (write_valid === 1'b1) wr_seen <= write_data;
		if (aborted === 1'b1) n_abort <= n_abort + 1;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// inputs change one ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	// bounded wait: 0 for a driven address phase, 1 for done
	task automatic wait_on(input int sel);
		for (int k = 0; k < 60; k++) begin
			if (sel == 0 && i_bus_cycle_if.addr_strobe_n === 1'b0 && i_bus_cycle_if.ctl_oe === 1'b1)
				return;
			if (sel == 1 && done === 1'b1) return;
			tick(1);
		end
		fails++;
		give_verdict();
	endtask : wait_on
	// one core request of kind i, up to its address phase
	task automatic launch(input int i);
		cur_wd = 64'h1234_5678_9abc_def0 ^ 64'(n_compared);
		use_dup_ready = i[0];
		req_kind = cycle_kind_type'(i[2:0]);
		req_addr = 29'h0abc_def0 + 29'(i);
		req_byte_en_n = ~(8'h01 << i);
		req_wdata = cur_wd;
		read_data = ~cur_wd;
		req_valid = 1'b1;
		tick(1);
		req_valid = 1'b0;
		check(req_ready, 1'b0);
		wait_on(0);
		check(i_bus_cycle_if.addr, req_addr);
		check(i_bus_cycle_if.addr_strobe_dup_n, 1'b0);
	endtask : launch
	// wait for completion and compare the data that moved
	task automatic finish(input int i);
		wait_on(1);
		tick(1);
		// the cycle is gone: request released and core may ask again
		check(req_ready, 1'b1);
		check(bus_request_seen, 1'b0);
		if (((8'h13 >> i) & 8'h01) != 8'h00) check(rdata, ~cur_wd);
		if (((8'h2c >> i) & 8'h01) != 8'h00) check(wr_seen, cur_wd);
	endtask : finish
	initial begin
		tick(20);
		check(drive_strong, `DRIVE_SEL_RST);
		rst = 1'b0;
		tick(3);
		check(drive_strong, 1'b0);
		// every cycle kind, alternating the ready copy
		for (int i = 0; i < 8; i++) begin
			launch(i);
			check(cyc_def, encs[i]);
			check(i_bus_cycle_if.cache_n, (8'hf4 >> i) & 8'h01);
			check(i_bus_cycle_if.byte_enable_n, req_byte_en_n);
			finish(i);
		end
		// backoff in a read address phase, then in a write data phase
		// non-cacheable requests from here on: a plain read must not flag
		req_cacheable = 1'b0;
		for (int j = 0; j < 2; j++) begin
			launch(2 * j);
			check(i_bus_cycle_if.cache_n, 1'b1);
			tick(j);
			backoff_req = 1'b1;
			tick(1);
			check(i_bus_cycle_if.ctl_oe, 1'b0);
			tick(3);
			check(i_bus_cycle_if.cpu_data_oe, 1'b0);
			check(bus_request_seen, 1'b1);
			backoff_req = 1'b0;
			wait_on(0);
			check(i_bus_cycle_if.addr, req_addr);
			finish(2 * j);
		end
		// backoff on an idle bus aborts nothing
		backoff_req = 1'b1;
		tick(2);
		backoff_req = 1'b0;
		tick(2);
		check(n_abort, 2);
		give_verdict();
	end
endmodule : tb_top
